// *** design/scs_status_flags.sv ***
// Serial status register with Wishbone slave, flag logic and interrupt requests
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module scs_status_flags #(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = scs_pkg::SCS_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [scs_pkg::SCS_SEL_W-1:0] i_wb_sel,
    input wire logic [scs_pkg::SCS_DATA_W-1:0] i_wb_dat,
    output logic [scs_pkg::SCS_DATA_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    // Datapath events
    input wire logic i_tx_ctrl_moved,
    input wire logic i_rx_ctrl_received,
    input wire logic i_tx_primary_load,
    input wire logic i_rx_primary_done,
    // FIFO levels and DMA service
    input wire logic [scs_pkg::SCS_CNT_W-1:0] i_tx_fifo_count,
    input wire logic [scs_pkg::SCS_CNT_W-1:0] i_rx_fifo_count,
    input wire logic i_tx_dma_en,
    input wire logic i_rx_dma_en,
    // FIFO soft resets
    output logic o_tx_fifo_soft_reset,
    output logic o_rx_fifo_soft_reset,
    // Interrupt requests
    output logic o_tx_control_empty_irq,
    output logic o_rx_control_full_irq
);
    import scs_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [SCS_DATA_W-1:0] byte_merge(
        input logic [SCS_DATA_W-1:0] old_val,
        input logic [SCS_DATA_W-1:0] new_val,
        input logic [SCS_SEL_W-1:0] sel
    );
        logic [SCS_DATA_W-1:0] res;
        res = old_val;
        for (int b = 0; b < SCS_SEL_W; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] adr,
        input logic [7:0] offset
    );
        return adr == ADDR_W'(offset);
    endfunction

    function automatic logic [SCS_STATUS_W-1:0] flags_to_status(
        input logic [SCS_NFLAG-1:0] f
    );
        logic [SCS_STATUS_W-1:0] s;
        s = '0;
        for (int i = 0; i < SCS_NFLAG; i++)
        begin
            s[SCS_FLAG_POS[i]] = f[i];
        end
        return s & SCS_STATUS_MASK;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    scs_bus_state_type bus_q;
    scs_bus_state_type bus_d;
    logic ack_q;
    logic ack_d;
    logic [SCS_DATA_W-1:0] rdat_q;
    logic [SCS_DATA_W-1:0] rdat_d;
    logic [SCS_CTRL_W-1:0] ctrl_q;
    logic [SCS_CTRL_W-1:0] ctrl_d;
    logic tcd_boot_q;
    logic tcd_boot_d;
    logic tx_irq_q;
    logic tx_irq_d;
    logic rx_irq_q;
    logic rx_irq_d;

    logic req;
    logic taken;
    logic first;
    logic hit_status;
    logic hit_ctrl;
    logic hit_level;
    logic status_wr;
    logic [SCS_WM_W-1:0] tx_wm;
    logic [SCS_WM_W-1:0] rx_wm;
    logic [SCS_CNT_W-1:0] tx_wm_ext;
    logic [SCS_CNT_W-1:0] rx_wm_ext;
    logic [SCS_CNT_W-1:0] depth_cnt;
    logic tx_at_or_below;
    logic rx_at_or_above;
    logic [SCS_STATUS_W-1:0] status_val;
    logic [SCS_DATA_W-1:0] level_val;

    scs_flag_if #(.N(SCS_NFLAG)) fl ();

    // ------------------------------------------------------------------
    // Address decode and request timing
    // ------------------------------------------------------------------
    assign req = i_wb_cyc && i_wb_stb;
    assign first = req && (bus_q == SCS_BUS_IDLE);
    assign taken = req && (bus_q == SCS_BUS_ACK);
    assign hit_status = reg_hit(i_wb_adr, SCS_OFF_STATUS);
    assign hit_ctrl = reg_hit(i_wb_adr, SCS_OFF_CTRL);
    assign hit_level = reg_hit(i_wb_adr, SCS_OFF_LEVEL);
    assign status_wr = taken && i_wb_we && hit_status && (i_wb_sel[0] || i_wb_sel[1]);

    // ------------------------------------------------------------------
    // Level comparisons
    // ------------------------------------------------------------------
    assign tx_wm = ctrl_q[SCS_C_TXWM_LSB +: SCS_WM_W];
    assign rx_wm = ctrl_q[SCS_C_RXWM_LSB +: SCS_WM_W];
    assign tx_wm_ext = SCS_CNT_W'(tx_wm);
    assign rx_wm_ext = SCS_CNT_W'(rx_wm);
    assign depth_cnt = SCS_CNT_W'(FIFO_DEPTH);
    assign tx_at_or_below = i_tx_fifo_count <= tx_wm_ext;
    assign rx_at_or_above = i_rx_fifo_count >= rx_wm_ext;

    // ------------------------------------------------------------------
    // Flag bank controls
    // ------------------------------------------------------------------
    always_comb
    begin
        fl.set = '0;
        fl.init = '0;
        fl.hw_clr = '0;
        fl.wr_zero = '0;
        fl.wr_any = status_wr;
        fl.rd_snap = first && !i_wb_we && hit_status;

        // Hardware set events
        fl.set[SCS_F_TXCTL] = i_tx_ctrl_moved || tcd_boot_q;
        fl.set[SCS_F_RXCTL] = i_rx_ctrl_received;
        fl.set[SCS_F_TXUND] = i_tx_primary_load && (i_tx_fifo_count == '0);
        fl.set[SCS_F_RXOVR] = i_rx_primary_done && (i_rx_fifo_count >= depth_cnt);
        fl.set[SCS_F_TXLOW] = tx_at_or_below;
        fl.set[SCS_F_RXWAIT] = rx_at_or_above;

        // Soft resets hold the affected flags at their reset values
        if (ctrl_q[SCS_C_TX_SRST])
        begin
            fl.init = fl.init | SCS_TX_INIT_MASK;
        end
        if (ctrl_q[SCS_C_RX_SRST])
        begin
            fl.init = fl.init | SCS_RX_INIT_MASK;
        end

        // DMA service clears the level flags without software
        fl.hw_clr[SCS_F_TXLOW] = i_tx_dma_en && !tx_at_or_below;
        fl.hw_clr[SCS_F_RXWAIT] = i_rx_dma_en && !rx_at_or_above;

        // Only zero bits in enabled lanes clear; ones are ignored
        for (int i = 0; i < SCS_NFLAG; i++)
        begin
            fl.wr_zero[i] = status_wr && i_wb_sel[SCS_FLAG_POS[i] / 8]
                && !i_wb_dat[SCS_FLAG_POS[i]];
        end
    end

    scs_flag_bank #(
        .N(SCS_NFLAG),
        .RESET_VAL(SCS_FLAG_RESET)
    ) u_flags (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .fl(fl.bank)
    );

    // ------------------------------------------------------------------
    // Read values
    // ------------------------------------------------------------------
    assign status_val = flags_to_status(fl.flag);

    always_comb
    begin
        level_val = '0;
        level_val[0 +: SCS_CNT_W] = i_tx_fifo_count;
        level_val[SCS_LVL_RX_LSB +: SCS_CNT_W] = i_rx_fifo_count;
    end

    // ------------------------------------------------------------------
    // Bus handshake and read data
    // ------------------------------------------------------------------
    always_comb
    begin
        bus_d = bus_q;
        ack_d = 1'b0;
        rdat_d = rdat_q;
        case (bus_q)
            SCS_BUS_IDLE:
            begin
                if (req)
                begin
                    bus_d = SCS_BUS_ACK;
                    ack_d = 1'b1;
                    rdat_d = '0;
                    if (!i_wb_we && hit_status)
                    begin
                        rdat_d[0 +: SCS_STATUS_W] = status_val;
                    end
                    else if (!i_wb_we && hit_ctrl)
                    begin
                        rdat_d[0 +: SCS_CTRL_W] = ctrl_q;
                    end
                    else if (!i_wb_we && hit_level)
                    begin
                        rdat_d = level_val;
                    end
                end
            end
            SCS_BUS_ACK:
            begin
                bus_d = SCS_BUS_IDLE;
                ack_d = 1'b0;
            end
            default:
            begin
                bus_d = SCS_BUS_IDLE;
                ack_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            bus_q <= SCS_BUS_IDLE;
            ack_q <= 1'b0;
            rdat_q <= '0;
        end
        else
        begin
            bus_q <= bus_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [SCS_DATA_W-1:0] merged;
        merged = '0;
        ctrl_d = ctrl_q;
        if (taken && i_wb_we && hit_ctrl)
        begin
            merged = byte_merge(SCS_DATA_W'(ctrl_q), i_wb_dat, i_wb_sel);
            ctrl_d = merged[SCS_CTRL_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            ctrl_q <= SCS_CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // Post-reset control-empty set
    // ------------------------------------------------------------------
    always_comb
    begin
        tcd_boot_d = 1'b0;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            tcd_boot_q <= 1'b1;
        end
        else
        begin
            tcd_boot_q <= tcd_boot_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------
    always_comb
    begin
        tx_irq_d = fl.flag[SCS_F_TXCTL] && ctrl_q[SCS_C_TX_CONTROL_EMPTY_IRQ_EN];
        rx_irq_d = fl.flag[SCS_F_RXCTL] && ctrl_q[SCS_C_RX_CONTROL_FULL_IRQ_EN];
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            tx_irq_q <= 1'b0;
            rx_irq_q <= 1'b0;
        end
        else
        begin
            tx_irq_q <= tx_irq_d;
            rx_irq_q <= rx_irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_tx_fifo_soft_reset = ctrl_q[SCS_C_TX_SRST];
    assign o_rx_fifo_soft_reset = ctrl_q[SCS_C_RX_SRST];
    assign o_tx_control_empty_irq = tx_irq_q;
    assign o_rx_control_full_irq = rx_irq_q;

endmodule
`default_nettype wire

// *** pkg/scs_pkg.sv ***
// Constants, field layout and types of the serial status flag block
package scs_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int SCS_DATA_W = 32;
    localparam int SCS_SEL_W = 4;
    localparam int SCS_STATUS_W = 16;
    localparam logic [7:0] SCS_OFF_STATUS = 8'h00;
    localparam logic [7:0] SCS_OFF_CTRL = 8'h04;
    localparam logic [7:0] SCS_OFF_LEVEL = 8'h08;
    localparam logic [15:0] SCS_STATUS_RESET = 16'h0002;
    localparam logic [15:0] SCS_STATUS_MASK = 16'h030f;

    // ------------------------------------------------------------------
    // Flag bank: index order and status bit positions
    // ------------------------------------------------------------------
    localparam int SCS_NFLAG = 6;
    localparam int SCS_F_RXWAIT = 0;
    localparam int SCS_F_TXLOW = 1;
    localparam int SCS_F_RXOVR = 2;
    localparam int SCS_F_TXUND = 3;
    localparam int SCS_F_RXCTL = 4;
    localparam int SCS_F_TXCTL = 5;
    localparam int SCS_FLAG_POS [SCS_NFLAG] = '{0, 1, 2, 3, 8, 9};
    localparam logic [5:0] SCS_FLAG_RESET = 6'h02;
    localparam logic [5:0] SCS_TX_INIT_MASK = 6'h0a;
    localparam logic [5:0] SCS_RX_INIT_MASK = 6'h05;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int SCS_WM_W = 4;
    localparam int SCS_FIFO_DEPTH = 16;
    localparam int SCS_CNT_W = 5;
    localparam int SCS_CTRL_W = 14;
    localparam logic [13:0] SCS_CTRL_RESET = 14'h0000;
    localparam int SCS_C_TX_SRST = 0;
    localparam int SCS_C_RX_SRST = 1;
    localparam int SCS_C_TXWM_LSB = 4;
    localparam int SCS_C_RXWM_LSB = 8;
    localparam int SCS_C_TX_CONTROL_EMPTY_IRQ_EN = 12;
    localparam int SCS_C_RX_CONTROL_FULL_IRQ_EN = 13;
    localparam int SCS_LVL_RX_LSB = 8;

    // ------------------------------------------------------------------
    // Bus handshake states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCS_BUS_IDLE = 2'b01,
        SCS_BUS_ACK = 2'b10
    } scs_bus_state_type;

endpackage

// *** pkg/scs_flag_if.sv ***
// Carrier between the register front end and the flag bank
`timescale 1ns/1ps
`default_nettype none
interface scs_flag_if #(
    parameter int N = 6
);
    logic [N-1:0] set;
    logic [N-1:0] init;
    logic [N-1:0] hw_clr;
    logic [N-1:0] wr_zero;
    logic wr_any;
    logic rd_snap;
    logic [N-1:0] flag;

    modport ctl (
        output set,
        output init,
        output hw_clr,
        output wr_zero,
        output wr_any,
        output rd_snap,
        input flag
    );

    modport bank (
        input set,
        input init,
        input hw_clr,
        input wr_zero,
        input wr_any,
        input rd_snap,
        output flag
    );
endinterface
`default_nettype wire

// *** design/scs_flag_bank.sv ***
// Bank of status flags with read-then-clear memory
`timescale 1ns/1ps
`default_nettype none
module scs_flag_bank #(
    parameter int N = 6,
    parameter logic [N-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Flag controls
    scs_flag_if.bank fl
);
    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;
    logic [N-1:0] armed_q;
    logic [N-1:0] armed_d;

    // ------------------------------------------------------------------
    // Next flag and read memory
    // ------------------------------------------------------------------
    always_comb
    begin
        flag_d = flag_q;
        armed_d = armed_q;
        for (int i = 0; i < N; i++)
        begin
            if (fl.init[i])
            begin
                flag_d[i] = RESET_VAL[i];
                armed_d[i] = 1'b0;
            end
            else if (fl.set[i])
            begin
                // Set beats a DMA or write clear in the same cycle
                flag_d[i] = 1'b1;
                if (!flag_q[i])
                begin
                    armed_d[i] = 1'b0;
                end
                else if (fl.rd_snap)
                begin
                    armed_d[i] = 1'b1;
                end
                else if (fl.wr_any)
                begin
                    armed_d[i] = 1'b0;
                end
            end
            else if (fl.hw_clr[i] || (fl.wr_zero[i] && armed_q[i]))
            begin
                flag_d[i] = 1'b0;
                armed_d[i] = 1'b0;
            end
            else if (fl.rd_snap && flag_q[i])
            begin
                armed_d[i] = 1'b1;
            end
            else if (fl.wr_any)
            begin
                armed_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            flag_q <= RESET_VAL;
            armed_q <= '0;
        end
        else
        begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end

    assign fl.flag = flag_q;
endmodule
`default_nettype wire

// *** sim/scs_codec_model.sv ***
// Far-side model: transfer events, FIFO levels and DMA service
`timescale 1ns/1ps
`default_nettype none
module scs_codec_model (
    // Clock and FIFO soft resets
    input wire logic i_sys_clk,
    input wire logic i_tx_srst,
    input wire logic i_rx_srst,
    // Events, levels and DMA service
    output logic [3:0] o_ev,
    output logic [scs_pkg::SCS_CNT_W-1:0] o_tx_cnt,
    output logic [scs_pkg::SCS_CNT_W-1:0] o_rx_cnt,
    output logic o_tx_dma,
    output logic o_rx_dma
);
    import scs_pkg::*;
    initial
    begin
        {o_ev, o_tx_cnt, o_rx_cnt, o_tx_dma, o_rx_dma} = '0;
    end
    // Soft reset empties the FIFO
    always @(posedge i_sys_clk)
    begin
        if (i_tx_srst)
            o_tx_cnt <= '0;
        if (i_rx_srst)
            o_rx_cnt <= '0;
    end
    task automatic pulse(input int k);
        @(posedge i_sys_clk);
        o_ev[k] <= 1'b1;
        @(posedge i_sys_clk);
        o_ev[k] <= 1'b0;
    endtask
    task automatic level(input logic [4:0] t, input logic [4:0] r, input logic td, input logic rd);
        @(posedge i_sys_clk);
        o_tx_cnt <= t;
        o_rx_cnt <= r;
        o_tx_dma <= td;
        o_rx_dma <= rd;
    endtask
endmodule
`default_nettype wire

// *** sim/scs_status_monitor.sv ***
// Assertion checker for the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module scs_status_monitor #(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [scs_pkg::SCS_DATA_W-1:0] i_wb_dat,
    input wire logic [scs_pkg::SCS_DATA_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    // Events and levels
    input wire logic i_tx_ctrl_moved,
    input wire logic i_tx_primary_load,
    input wire logic i_rx_primary_done,
    input wire logic [scs_pkg::SCS_CNT_W-1:0] i_tx_fifo_count,
    input wire logic [scs_pkg::SCS_CNT_W-1:0] i_rx_fifo_count,
    // Soft resets and request
    input wire logic o_tx_fifo_soft_reset,
    input wire logic o_rx_fifo_soft_reset,
    input wire logic o_tx_control_empty_irq
);
    import scs_pkg::*;
    logic take;
    logic wr_ack;
    logic [4:0] wm;
    logic [13:0] ctl_q;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    // Status read taken; shadow of the control word
    assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack & ~i_wb_we & (i_wb_adr == ADDR_W'(SCS_OFF_STATUS));
    assign wr_ack = o_wb_ack & i_wb_we;
    assign wm = {1'b0, ctl_q[7:4]};
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            ctl_q <= '0;
        else if (wr_ack && i_wb_adr == ADDR_W'(SCS_OFF_CTRL))
            ctl_q <= i_wb_dat[13:0];
    end
    AST_RSVD_ZERO: assert property (take |=> (o_wb_dat & 32'hfffffcf0) == '0)
        else $error("reserved status bits set");
    AST_TX_CONTROL_EMPTY_IRQ_EN_OFF: assert property (!ctl_q[12] && !$past(ctl_q[12]) |-> !o_tx_control_empty_irq)
        else $error("control empty request without enable");
    AST_TXRST_HOLD: assert property (take && o_tx_fifo_soft_reset && $past(o_tx_fifo_soft_reset)
        |=> (o_wb_dat[3:0] & 4'ha) == 4'h2) else $error("tx flags not initialised");
    AST_RXRST_HOLD: assert property (take && o_rx_fifo_soft_reset && $past(o_rx_fifo_soft_reset)
        |=> (o_wb_dat[3:0] & 4'h5) == 4'h0) else $error("rx flags not initialised");
    AST_UNDERRUN: assert property (i_tx_primary_load && i_tx_fifo_count == '0 && !o_tx_fifo_soft_reset
        ##1 !wr_ack && !o_tx_fifo_soft_reset ##1 take && !o_tx_fifo_soft_reset |=> o_wb_dat[3])
        else $error("underrun not flagged");
    AST_OVERRUN: assert property (i_rx_primary_done && i_rx_fifo_count >= FIFO_DEPTH
        && !o_rx_fifo_soft_reset ##1 !wr_ack && !o_rx_fifo_soft_reset ##1 take && !o_rx_fifo_soft_reset
        |=> o_wb_dat[2]) else $error("overrun not flagged");
    AST_CTL_EMPTY: assert property (i_tx_ctrl_moved ##1 !wr_ack ##1 take |=> o_wb_dat[9])
        else $error("control empty not flagged");
    AST_TXLOW: assert property (take && $past(i_tx_fifo_count) <= $past(wm) |=> o_wb_dat[1])
        else $error("fifo low not flagged");
    cover property (take && o_tx_fifo_soft_reset);
    cover property (i_tx_primary_load && i_tx_fifo_count == '0);
    cover property (o_tx_control_empty_irq);
endmodule
bind scs_status_flags scs_status_monitor #(.ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH)) u_scs_status_monitor (.*);
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scs_pkg::*;
    logic i_sys_clk, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
    logic [7:0] i_wb_adr;
    logic [SCS_SEL_W-1:0] i_wb_sel;
    logic [SCS_DATA_W-1:0] i_wb_dat, o_wb_dat;
    logic i_tx_ctrl_moved, i_rx_ctrl_received, i_tx_primary_load, i_rx_primary_done;
    logic [SCS_CNT_W-1:0] i_tx_fifo_count, i_rx_fifo_count;
    logic i_tx_dma_en, i_rx_dma_en, o_tx_fifo_soft_reset, o_rx_fifo_soft_reset;
    logic o_tx_control_empty_irq, o_rx_control_full_irq;
    int error_cnt = 0;
    int comparisons = 0;
    scs_status_flags u_scs_status_flags (.*);
    scs_codec_model u_scs_codec_model (
        .i_sys_clk(i_sys_clk),
        .i_tx_srst(o_tx_fifo_soft_reset),
        .i_rx_srst(o_rx_fifo_soft_reset),
        .o_ev({i_rx_primary_done, i_tx_primary_load, i_rx_ctrl_received, i_tx_ctrl_moved}),
        .o_tx_cnt(i_tx_fifo_count),
        .o_rx_cnt(i_rx_fifo_count),
        .o_tx_dma(i_tx_dma_en),
        .o_rx_dma(i_rx_dma_en)
    );
    initial
    begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    // ------------------------------------------------
    // Bus and checking helpers
    // ------------------------------------------------
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        @(posedge i_sys_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        n = 0;
        do
        begin
            @(posedge i_sys_clk);
            n++;
        end
        while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] bus wait expected ack seen none");
            end_sim();
        end
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask
    task automatic st(input string name, input logic [15:0] m, input logic [15:0] e);
        logic [31:0] d;
        wb(1'b0, SCS_OFF_STATUS, '0, d);
        check("reserved", d & 32'hfffffcf0, '0);
        check(name, {16'h0000, d[15:0] & m}, {16'h0000, e});
    endtask
    task automatic irq(input logic tx, input logic rx);
        repeat (2) @(posedge i_sys_clk);
        check("requests", {30'h0, o_tx_control_empty_irq, o_rx_control_full_irq}, {30'h0, tx, rx});
    endtask
    task automatic ev(input int k);
        u_scs_codec_model.pulse(k);
    endtask
    task automatic lv(input logic [4:0] t, input logic [4:0] r, input logic td, input logic rd);
        u_scs_codec_model.level(t, r, td, rd);
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        st("after reset", 16'hffff, 16'h0203);
        wr(8'h0c, 32'h0000ffff);
        wb(1'b0, 8'h0c, '0, d);
        check("unmapped", d, '0);
        $display("test reset done");
    endtask
    task automatic t_tx_ctrl();
        wr(SCS_OFF_STATUS, 32'h030f);
        wr(SCS_OFF_STATUS, 32'h010f);
        st("ctl empty unarmed", 16'h0200, 16'h0200);
        wr(SCS_OFF_STATUS, 32'h010f);
        st("ctl empty clear", 16'h0200, 16'h0000);
        wr(SCS_OFF_CTRL, 32'h1000);
        irq(1'b0, 1'b0);
        ev(0);
        st("ctl empty set", 16'h0200, 16'h0200);
        irq(1'b1, 1'b0);
        wr(SCS_OFF_CTRL, '0);
        irq(1'b0, 1'b0);
        $display("test tx control done");
    endtask
    task automatic t_rx_ctrl();
        wr(SCS_OFF_CTRL, 32'h2000);
        st("ctl full idle", 16'h0100, 16'h0000);
        ev(1);
        st("ctl full set", 16'h0100, 16'h0100);
        irq(1'b0, 1'b1);
        wr(SCS_OFF_STATUS, 32'h020f);
        st("ctl full clear", 16'h0100, 16'h0000);
        irq(1'b0, 1'b0);
        wr(SCS_OFF_CTRL, '0);
        $display("test rx control done");
    endtask
    task automatic t_underrun();
        lv(5'h01, 5'h00, 1'b0, 1'b0);
        ev(2);
        st("underrun with data", 16'h0008, 16'h0000);
        lv(5'h00, 5'h00, 1'b0, 1'b0);
        ev(2);
        st("underrun set", 16'h0008, 16'h0008);
        wr(SCS_OFF_STATUS, 32'h0307);
        st("underrun clear", 16'h0008, 16'h0000);
        wr(SCS_OFF_STATUS, 32'h030f);
        st("one written", 16'h0008, 16'h0000);
        ev(2);
        wr(SCS_OFF_CTRL, 32'h0001);
        st("tx fifo reset", 16'h000a, 16'h0002);
        check("tx soft reset", o_tx_fifo_soft_reset, 32'h1);
        wr(SCS_OFF_CTRL, '0);
        $display("test underrun done");
    endtask
    task automatic t_overrun();
        lv(5'h00, 5'h0f, 1'b0, 1'b0);
        ev(3);
        st("overrun not full", 16'h0004, 16'h0000);
        lv(5'h00, 5'h10, 1'b0, 1'b0);
        ev(3);
        st("overrun set", 16'h0004, 16'h0004);
        wr(SCS_OFF_STATUS, 32'h030b);
        st("overrun clear", 16'h0004, 16'h0000);
        ev(3);
        wr(SCS_OFF_CTRL, 32'h0002);
        st("rx fifo reset", 16'h0005, 16'h0000);
        check("rx soft reset", o_rx_fifo_soft_reset, 32'h1);
        wr(SCS_OFF_CTRL, '0);
        $display("test overrun done");
    endtask
    task automatic t_tx_low();
        logic [31:0] d;
        wr(SCS_OFF_CTRL, 32'h0040);
        wb(1'b0, SCS_OFF_CTRL, '0, d);
        check("control", d, 32'h00000040);
        lv(5'h04, 5'h00, 1'b0, 1'b0);
        wb(1'b0, SCS_OFF_LEVEL, '0, d);
        check("level", d, 32'h00000004);
        st("low at mark", 16'h0002, 16'h0002);
        wr(SCS_OFF_STATUS, 32'h030d);
        st("low kept at mark", 16'h0002, 16'h0002);
        lv(5'h05, 5'h00, 1'b0, 1'b0);
        st("low kept above", 16'h0002, 16'h0002);
        wr(SCS_OFF_STATUS, 32'h030d);
        st("low clear", 16'h0002, 16'h0000);
        lv(5'h04, 5'h00, 1'b0, 1'b0);
        st("low set again", 16'h0002, 16'h0002);
        lv(5'h05, 5'h00, 1'b1, 1'b0);
        st("low dma clear", 16'h0002, 16'h0000);
        lv(5'h00, 5'h00, 1'b0, 1'b0);
        wr(SCS_OFF_CTRL, '0);
        $display("test tx low done");
    endtask
    task automatic t_rx_wait();
        wr(SCS_OFF_CTRL, 32'h0400);
        lv(5'h00, 5'h04, 1'b0, 1'b0);
        st("wait at mark", 16'h0001, 16'h0001);
        lv(5'h00, 5'h03, 1'b0, 1'b0);
        st("wait kept", 16'h0001, 16'h0001);
        wr(SCS_OFF_STATUS, 32'h030e);
        st("wait clear", 16'h0001, 16'h0000);
        lv(5'h00, 5'h04, 1'b0, 1'b0);
        st("wait set again", 16'h0001, 16'h0001);
        lv(5'h00, 5'h03, 1'b0, 1'b1);
        st("wait dma clear", 16'h0001, 16'h0000);
        lv(5'h00, 5'h00, 1'b0, 1'b0);
        wr(SCS_OFF_CTRL, '0);
        $display("test rx wait done");
    endtask
    initial
    begin
        i_reset = 1'b1;
        i_wb_cyc = 1'b0;
        i_wb_stb = 1'b0;
        i_wb_we = 1'b0;
        i_wb_adr = '0;
        i_wb_sel = 4'hf;
        i_wb_dat = '0;
        repeat (16) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        t_reset();
        t_tx_ctrl();
        t_rx_ctrl();
        t_underrun();
        t_overrun();
        t_tx_low();
        t_rx_wait();
        end_sim();
    end
endmodule
`default_nettype wire
